// ===== rtl/scmc_core.v
// serial channel mode, clock source and wake-up control with shifter
`timescale 1ns/1ps
`include "scmc_regs.vh"
module scmc_core (
    input wire core_clk, // 50 MHz system clock
    input wire rst, // async reset, high
    // cpu register port
    input wire [15:0] cpu_addr, // register address
    input wire cpu_wr, // byte write strobe
    input wire cpu_bit_wr, // single-bit write strobe
    input wire [2:0] cpu_bit_sel, // bit index for bit write
    input wire cpu_bit_val, // value for bit write
    input wire [7:0] cpu_wdata, // byte write data
    output reg [7:0] cpu_rdata_r, // read data, one cycle late
    // transmit word
    input wire tx_valid, // word to load
    output wire tx_ready, // load accepted this cycle
    input wire [7:0] tx_data, // word to send
    // received word stream
    output wire rx_valid, // received word available
    input wire rx_ready, // consumer takes word
    output wire [7:0] rx_data, // received word
    output reg [7:0] shift_data_r, // shift register contents
    output wire busy, // transfer in progress
    output reg irq_r, // channel interrupt pulse
    // clock sources and slave address
    input wire eight_bit_timer_out, // timer output level
    input wire [15:0] prescaler_taps, // prescaler clock levels
    input wire [3:0] prescaler_clk_select, // prescaler tap choice
    input wire [7:0] slave_address_reg, // slave address value
    // pins
    input wire serial_clock_pin_i, // clock pin level
    output reg serial_clock_pin_o, // clock pin drive value
    output wire serial_clock_pin_oe, // clock pin driven
    input wire serial_in_pin, // serial data input
    output reg serial_out_pin_o, // serial data drive value
    output wire serial_out_pin_oe, // serial out driven
    input wire port_dir_in, // port direction of input pin
    output reg port_bit_in_r // input pin as port bit
);
    // ======================================================
    // registers
    reg [7:0] mode_r;
    reg [7:0] busctl_r;
    reg [7:0] mode_nxt;
    reg [7:0] busctl_nxt;
    wire sel_mode;
    wire sel_busctl;

    // ======================================================
    // decoded fields
    wire channel_enable_bit;
    wire address_match_flag;
    wire wake_on_address_bit;
    wire mode_sel_bit4;
    wire mode_sel_bit3;
    wire first_bit_order_sel;
    wire clk_src_sel_hi;
    wire clk_src_sel_lo;
    wire bus_mode;
    wire command_detected_flag;
    wire release_detected_flag;

    assign sel_mode = (cpu_addr == `SCMC_ADDR_MODE);
    assign sel_busctl = (cpu_addr == `SCMC_ADDR_BUSCTL);
    assign channel_enable_bit = mode_r[`SCMC_B_ENABLE];
    assign address_match_flag = mode_r[`SCMC_B_MATCH];
    assign wake_on_address_bit = mode_r[`SCMC_B_WAKE];
    assign mode_sel_bit4 = mode_r[`SCMC_B_MODE4];
    assign mode_sel_bit3 = mode_r[`SCMC_B_MODE3];
    assign first_bit_order_sel = mode_r[`SCMC_B_ORDER];
    assign clk_src_sel_hi = mode_r[`SCMC_B_CLKHI];
    assign clk_src_sel_lo = mode_r[`SCMC_B_CLKLO];
    // bits 4,3 at 1,0 pick the addressed bus mode
    assign bus_mode = mode_sel_bit4 & ~mode_sel_bit3; // see [RQ6]
    assign command_detected_flag = busctl_r[`SCMC_B_COMMAND_DETECTED_FLAG];
    assign release_detected_flag = busctl_r[`SCMC_B_RELEASE_DETECTED_FLAG];

    // ======================================================
    // shifter state
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_PUSH = 2'h2;

    reg [1:0] state_r;
    reg [7:0] shift_r;
    reg [3:0] cnt_r;
    reg src_prev_r;
    reg match_set;
    reg src_level;
    wire src_rise;
    wire src_fall;
    wire internal_clk;
    wire sck_rise;
    wire sck_fall;
    reg next_bit;
    reg [7:0] shifted;
    wire buf_in_ready;
    wire load;
    wire done;
    wire last_bit;
    wire first_tx_bit;

    // ======================================================
    // clock source selection
    // external pin when high select is 0, low select is ignored
    assign internal_clk = clk_src_sel_hi; // see [RQ2]
    always @* begin
        if (~clk_src_sel_hi) begin
            src_level = serial_clock_pin_i; // see [RQ2]
        end else if (~clk_src_sel_lo) begin
            src_level = eight_bit_timer_out; // see [RQ3]
        end else begin
            src_level = prescaler_taps[prescaler_clk_select]; // see [RQ4]
        end
    end
    // sources are taken as plain levels; they must be synchronous
    // the previous sample resets high like the idle pin: no false edge
    assign src_rise = src_level & ~src_prev_r;
    assign src_fall = ~src_level & src_prev_r;

    // internal clock: each source rise in ST_SHIFT toggles the driven pin, so the
    // shift clock runs at half the source rate
    assign sck_fall = internal_clk ? (src_rise & serial_clock_pin_o) :
        src_fall;
    assign sck_rise = internal_clk ? (src_rise & ~serial_clock_pin_o) :
        src_rise;

    // ======================================================
    // bit order and data movement
    // MSB first when order bit is 0, LSB first when it is 1
    always @* begin
        if (first_bit_order_sel) begin
            next_bit = shift_r[0]; // see [RQ5]
            shifted = {serial_in_pin, shift_r[7:1]};
        end else begin
            next_bit = shift_r[7]; // see [RQ5]
            shifted = {shift_r[6:0], serial_in_pin};
        end
    end

    // stopped channel takes loads at once as a plain register
    assign tx_ready = ~channel_enable_bit | (state_r == ST_IDLE); // see [RQ13]
    assign load = tx_valid & tx_ready;
    assign busy = (state_r != ST_IDLE);
    assign done = (state_r == ST_PUSH) & buf_in_ready;
    assign last_bit = (cnt_r == (`SCMC_BITS - `SCMC_CNT_ONE));
    assign first_tx_bit = first_bit_order_sel ? tx_data[0] : // see [RQ5]
        tx_data[7];

    // pins are handed to the port logic while stopped
    assign serial_clock_pin_oe = channel_enable_bit & // see [RQ13]
        internal_clk;
    assign serial_out_pin_oe = channel_enable_bit; // see [RQ13]

    // ======================================================
    // received word buffer
    // a full buffer holds the finished word and blocks the next load,
    // so a slow consumer costs throughput, never data
    scmc_buf2 u_rxbuf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(state_r == ST_PUSH),
        .in_ready(buf_in_ready),
        .in_data(shift_r),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // ======================================================
    // register writes
    // a byte write wins over a bit write in the same cycle
    always @* begin
        mode_nxt = mode_r;
        busctl_nxt = busctl_r;
        if (cpu_wr & sel_mode) begin
            mode_nxt = cpu_wdata;
        end else if (cpu_bit_wr & sel_mode) begin
            mode_nxt[cpu_bit_sel] = cpu_bit_val;
        end
        if (cpu_wr & sel_busctl) begin
            busctl_nxt = cpu_wdata; // see [RQ12]
        end else if (cpu_bit_wr & sel_busctl) begin
            busctl_nxt[cpu_bit_sel] = cpu_bit_val; // see [RQ12]
        end
        // the match bit ignores software and follows the device only
        mode_nxt = (mode_nxt & ~`SCMC_RO_MASK) | // see [RQ10]
            (mode_r & `SCMC_RO_MASK);
        if (~channel_enable_bit)
            mode_nxt[`SCMC_B_MATCH] = 1'b0;
        else if (done)
            mode_nxt[`SCMC_B_MATCH] = match_set; // see [RQ10]
    end

    // address match needs command and release both seen in bus mode
    always @* begin
        match_set = bus_mode & command_detected_flag & // see [RQ8]
            release_detected_flag & (shift_r == slave_address_reg);
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_r <= `SCMC_RESET_VAL;
            busctl_r <= `SCMC_RESET_VAL; // see [RQ12]
        end else begin
            mode_r <= mode_nxt;
            busctl_r <= busctl_nxt;
        end
    end

    // ======================================================
    // register reads
    // unmapped addresses read as zero, so stray reads are harmless
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu_rdata_r <= `SCMC_RD_NONE;
        end else if (sel_mode) begin
            cpu_rdata_r <= mode_r;
        end else if (sel_busctl) begin
            cpu_rdata_r <= busctl_r;
        end else begin
            cpu_rdata_r <= `SCMC_RD_NONE;
        end
    end

    // ======================================================
    // shift sequencer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            cnt_r <= `SCMC_CNT_ZERO;
            src_prev_r <= 1'b1;
            serial_clock_pin_o <= 1'b1;
            serial_out_pin_o <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            src_prev_r <= src_level;
            irq_r <= 1'b0;
            if (~channel_enable_bit) begin
                // no shifting at all while stopped
                // disabling aborts a transfer; the partial word is dropped
                state_r <= ST_IDLE; // see [RQ1]
                cnt_r <= `SCMC_CNT_ZERO;
                serial_clock_pin_o <= 1'b1;
                if (load)
                    shift_r <= tx_data; // see [RQ13]
            end else begin
                case (state_r)
                ST_IDLE: begin
                    serial_clock_pin_o <= 1'b1;
                    if (load) begin
                        shift_r <= tx_data;
                        // first bit goes out at load, ahead of the first fall
                        serial_out_pin_o <= first_tx_bit; // see [RQ5]
                        cnt_r <= `SCMC_CNT_ZERO;
                        state_r <= ST_SHIFT; // see [RQ1]
                    end
                end
                ST_SHIFT: begin
                    if (internal_clk & src_rise)
                        serial_clock_pin_o <= ~serial_clock_pin_o; // see [RQ3]
                    if (sck_fall & (cnt_r != `SCMC_CNT_ZERO))
                        serial_out_pin_o <= next_bit;
                    if (sck_rise) begin
                        shift_r <= shifted;
                        cnt_r <= cnt_r + `SCMC_CNT_ONE;
                        if (last_bit)
                            state_r <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    // held here while the buffer is full; loads wait too
                    serial_clock_pin_o <= 1'b1;
                    if (buf_in_ready) begin
                        state_r <= ST_IDLE;
                        // wake bit 0 interrupts on every transfer;
                        // software keeps it 0 in three-wire mode
                        irq_r <= ~wake_on_address_bit | // see [RQ7] [RQ9]
                            match_set; // see [RQ8]
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
                endcase
            end
        end
    end

    // ======================================================
    // port view of the serial input pin
    // sampled while port_dir_in is set, held otherwise, so a transmit-only channel leaves it usable
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port_bit_in_r <= 1'b0;
            shift_data_r <= 8'h00;
        end else begin
            port_bit_in_r <= port_dir_in ? serial_in_pin : // see [RQ11]
                port_bit_in_r;
            shift_data_r <= shift_r;
        end
    end
endmodule // scmc_core

// ===== rtl/scmc_regs.vh
// constants for the serial channel mode control block
// What this block does
// [RQ1] mode bit 7 enables the channel; at 0 nothing transfers
// [RQ2] clock select high bit 0 takes shift clock from external pin
// [RQ3] select 1,0 uses the 8-bit timer output and drives the clock pin
// [RQ4] select 1,1 uses the prescaler clock chosen by its low four bits
// [RQ5] mode bit 4 at 0 is three-wire; bit 2 picks MSB or LSB first
// [RQ6] mode bits 4,3 at 1,0 select the addressed bus mode
// [RQ7] wake bit 0 raises the interrupt after every transfer
// [RQ8] wake bit 1 in bus mode interrupts only on slave address match
// [RQ9] software keeps the wake bit 0 in three-wire mode
// [RQ10] mode bit 6 is read-only and updated by the device only
// [RQ11] in transmit-only use the serial input stays a general input
// [RQ12] reset clears the bus control register; bit and byte writes
// [RQ13] stopped channel: shift register is a plain register, pins general
`ifndef SCMC_REGS_VH
`define SCMC_REGS_VH

// ==========================================================
// register map
`define SCMC_ADDR_MODE 16'hFF60
`define SCMC_ADDR_BUSCTL 16'hFF61
`define SCMC_RESET_VAL 8'h00
`define SCMC_RD_NONE 8'h00

// ==========================================================
// mode register fields
`define SCMC_B_ENABLE 7
`define SCMC_B_MATCH 6
`define SCMC_B_WAKE 5
`define SCMC_B_MODE4 4
`define SCMC_B_MODE3 3
`define SCMC_B_ORDER 2
`define SCMC_B_CLKHI 1
`define SCMC_B_CLKLO 0
`define SCMC_RO_MASK 8'h40

// ==========================================================
// bus control register fields
`define SCMC_B_COMMAND_DETECTED_FLAG 3
`define SCMC_B_RELEASE_DETECTED_FLAG 2

// ==========================================================
// shifter
`define SCMC_BITS 4'h8
`define SCMC_CNT_ZERO 4'h0
`define SCMC_CNT_ONE 4'h1

`endif

// ===== rtl/scmc_buf2.v
// two-entry buffer for received serial words
`timescale 1ns/1ps
module scmc_buf2 (
    input wire core_clk, // system clock
    input wire rst, // async reset, high
    input wire in_valid, // word offered
    output wire in_ready, // room for a word
    input wire [7:0] in_data, // word in
    output wire out_valid, // word available
    input wire out_ready, // consumer takes word
    output wire [7:0] out_data // oldest word
);
    reg [7:0] mem_r [0:1];
    reg wptr_r;
    reg rptr_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= 8'h00;
            mem_r[1] <= 8'h00;
        end else begin
            if (push) begin
                mem_r[wptr_r] <= in_data;
                wptr_r <= ~wptr_r;
            end
            if (pop)
                rptr_r <= ~rptr_r;
            if (push & ~pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule // scmc_buf2

// ===== dv/scmc_chk_properties.sv
// assertion checker for the serial channel mode control block
`timescale 1ns/1ps
module scmc_chk (
    input wire core_clk, // clock
    input wire rst, // reset
    input wire [15:0] cpu_addr, // address
    input wire cpu_wr, // byte write
    input wire cpu_bit_wr, // bit write
    input wire [2:0] cpu_bit_sel, // bit index
    input wire cpu_bit_val, // bit value
    input wire [7:0] cpu_wdata, // write data
    input wire [7:0] cpu_rdata_r, // read data
    input wire tx_ready, // load ok
    input wire busy, // shifting
    input wire irq_r, // interrupt
    input wire rx_valid, // word ready
    input wire serial_clock_pin_o, // clock drive
    input wire serial_clock_pin_oe, // clock enable
    input wire serial_out_pin_oe, // out enable
    input wire serial_in_pin, // data in
    input wire port_dir_in, // port dir
    input wire port_bit_in_r // port bit
);
    logic [7:0] m_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ====================
    // mode shadow; bit 6 left out as software cannot set it
    always @(posedge core_clk or posedge rst) begin
        if (rst) m_r <= 8'h00;
        else if (cpu_wr && cpu_addr == 16'hFF60) m_r <= cpu_wdata & 8'hBF;
        else if (cpu_bit_wr && cpu_addr == 16'hFF60 && cpu_bit_sel != 3'h6)
            m_r[cpu_bit_sel] <= cpu_bit_val;
    end
    AST_SO_OE: assert property (serial_out_pin_oe == m_r[7])
        else $error("serial out enable wrong");
    AST_CLK_OE: assert property
        (serial_clock_pin_oe == (m_r[7] && m_r[1]))
        else $error("clock pin enable wrong");
    AST_TX_READY: assert property
        (tx_ready == (!m_r[7] || !busy))
        else $error("load ready wrong");
    AST_STOP_IDLE: assert property
        (!m_r[7] && $past(m_r[7]) == 1'b0 |-> !busy && serial_clock_pin_o)
        else $error("stopped channel not idle");
    AST_RD_MODE: assert property
        ($past(cpu_addr) == 16'hFF60 |->
         ((cpu_rdata_r ^ $past(m_r)) & 8'hBF) == 8'h00)
        else $error("mode readback wrong");
    AST_RO_OFF: assert property
        ($past(cpu_addr) == 16'hFF60 && $past(m_r[7]) == 1'b0 &&
         $past(m_r[7], 2) == 1'b0 |-> cpu_rdata_r[6] == 1'b0)
        else $error("match bit set while stopped");
    AST_IRQ_ONE: assert property (irq_r |=> !irq_r)
        else $error("interrupt longer than one cycle");
    AST_IRQ_CAUSE: assert property
        (irq_r |-> $past(busy) && rx_valid)
        else $error("interrupt without transfer end");
    AST_PORT: assert property
        (port_dir_in |=> port_bit_in_r == $past(serial_in_pin))
        else $error("port bit not following input");
    AST_PORT_HOLD: assert property
        (!port_dir_in |=> $stable(port_bit_in_r))
        else $error("port bit moved");
    cover property (irq_r);
    cover property (busy && serial_clock_pin_oe);
    cover property (busy && !tx_ready);
endmodule // scmc_chk
bind scmc_core scmc_chk u_chk (.*);

// ===== dv/scmc_peer.sv
// far-side clocked serial peripheral model
`timescale 1ns/1ps
module scmc_peer (
    input wire core_clk, // clock
    input wire go, // frame start
    input wire lsb, // low bit first
    input wire [7:0] word, // word to send
    input wire dev_clk, // device clock drive
    input wire dev_clk_oe, // device drives clock
    input wire so, // device serial out
    output wire pin_clk, // clock pin level
    output logic sdi, // data to device
    output logic [7:0] got // word received
);
    logic ext = 1'b1;
    int idx = 8;
    initial sdi = 1'b1;
    assign pin_clk = dev_clk_oe ? dev_clk : ext;
    always @(posedge go) begin
        idx = 0;
        sdi <= lsb ? word[0] : word[7];
        if (!dev_clk_oe) begin
            repeat (8) begin
                repeat (3) @(posedge core_clk);
                ext <= 1'b0;
                repeat (3) @(posedge core_clk);
                ext <= 1'b1;
            end
        end
    end
    always @(negedge pin_clk)
        if (idx < 8) sdi <= lsb ? word[idx] : word[7 - idx];
    always @(posedge pin_clk) if (idx < 8) begin
        got <= lsb ? {so, got[7:1]} : {got[6:0], so};
        idx++;
        // released line shows the inverse, after a hold of three cycles
        if (idx == 8) sdi <= #60 ~sdi;
    end
endmodule // scmc_peer

// ===== dv/tb_serial_channel_mode_control.sv
// self-checking bench for the serial channel mode control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    n_errors++; $display("BAD t=%0t %h %h", $time, a, b); end end
module tb_serial_channel_mode_control;
    logic core_clk = 0, rst = 1, cpu_wr = 0, cpu_bit_wr = 0, cpu_bit_val = 0;
    logic tx_valid = 0, rx_ready = 0, port_dir_in = 0, go = 0, lsb = 0;
    logic irq_seen = 0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [2:0] cpu_bit_sel = 3'h0;
    logic [7:0] cpu_wdata = 8'h00, tx_data = 8'h00, sa = 8'h00, word = 8'h00;
    logic [7:0] r, m, cnt = 8'h00, bc = 8'h0C;
    logic [3:0] psel = 4'h0;
    logic [1:0] src = 2'h0;
    logic [7:0] q[$];
    int n_errors = 0, total_checks = 0, i;
    wire [7:0] cpu_rdata_r, rx_data, shift_data_r, got;
    wire tx_ready, rx_valid, busy, irq_r, pin_clk, sdi, port_bit_in_r;
    wire serial_clock_pin_o, serial_clock_pin_oe;
    wire serial_out_pin_o, serial_out_pin_oe;
    always #10 core_clk = ~core_clk;
    always @(negedge core_clk) cnt <= cnt + 8'h01;
    always @(posedge core_clk) if (irq_r === 1'b1) irq_seen <= 1'b1;
    // ====================
    // design and far side; only the selected source ever toggles
    scmc_core dut (.*, .eight_bit_timer_out(src == 2'h2 && cnt[1]),
        .prescaler_taps(src == 2'h3 ? {15'h0000, cnt[1]} << psel : 16'h0000),
        .prescaler_clk_select(psel), .slave_address_reg(sa),
        .serial_clock_pin_i(pin_clk), .serial_in_pin(sdi));
    scmc_peer peer (.core_clk(core_clk), .go(go), .lsb(lsb), .word(word),
        .dev_clk(serial_clock_pin_o), .dev_clk_oe(serial_clock_pin_oe),
        .so(serial_out_pin_o), .pin_clk(pin_clk), .sdi(sdi), .got(got));
    task wr(input [15:0] a, input [7:0] d);
        cpu_addr = a; cpu_wdata = d; cpu_wr = 1; @(negedge core_clk);
        cpu_wr = 0; @(negedge core_clk);
    endtask
    task bwr(input [15:0] a, input [2:0] b, input v);
        cpu_addr = a; cpu_bit_sel = b; cpu_bit_val = v; cpu_bit_wr = 1;
        @(negedge core_clk); cpu_bit_wr = 0; @(negedge core_clk);
    endtask
    task rd(input [15:0] a, input [7:0] e);
        cpu_addr = a; @(negedge core_clk);
        `CHK(cpu_rdata_r, e)
    endtask
    task pop;
        r = q.pop_front();
        `CHK(rx_valid, 1'b1)
        `CHK(rx_data, r)
        rx_ready = 1; @(negedge core_clk); rx_ready = 0; @(negedge core_clk);
    endtask
    // expected interrupt from the mode word and the received address
    function automatic logic exp_irq(input [7:0] md, input [7:0] w);
        exp_irq = !md[5] || (md[4] && !md[3] && bc[3] && bc[2] && w == sa);
    endfunction
    // bounded wait: a stalled push simply runs the limit out
    // e is low when the push is expected to stall on a full buffer
    task xfer(input [7:0] md, input [7:0] t, input [7:0] w, input e, input p);
        src = md[1:0]; wr(16'hFF60, md);
        word = w; lsb = md[2]; tx_data = t; tx_valid = 1;
        go = 1; irq_seen = 0;
        @(negedge core_clk); tx_valid = 0; go = 0; i = 0;
        while (busy !== 1'b0 && i < 400) begin @(negedge core_clk); i++; end
        @(negedge core_clk); q.push_back(w);
        `CHK(irq_seen, e & exp_irq(md, w))
        `CHK(got, t)
        if (p) pop();
    endtask
    task close_out;
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1500000; n_errors++; close_out();
    end
    initial begin
        i = $urandom(3841);
        repeat (4) @(negedge core_clk); rst = 0;
        rd(16'hFF60, 8'h00);
        rd(16'hFF61, 8'h00);
        rd(16'h1234, 8'h00);
        r = 8'($urandom); wr(16'hFF61, r); rd(16'hFF61, r);
        bwr(16'hFF61, 3'h0, ~r[0]); rd(16'hFF61, r ^ 8'h01);
        wr(16'hFF60, 8'h40); rd(16'hFF60, 8'h00);
        bwr(16'hFF60, 3'h6, 1'b1); rd(16'hFF60, 8'h00);
        r = 8'($urandom); tx_data = r; tx_valid = 1; @(negedge core_clk);
        tx_valid = 0; @(negedge core_clk); @(negedge core_clk);
        `CHK(shift_data_r, r)
        `CHK(busy, 1'b0)
        port_dir_in = 1; @(negedge core_clk); @(negedge core_clk);
        `CHK(port_bit_in_r, sdi)
        wr(16'hFF61, bc);
        for (int c = 0; c < 6; c++) begin
            psel = 4'($urandom);
            m = 8'h80 | {5'h00, c[0], (c < 2) ? 2'h0 : (c < 4) ? 2'h2 : 2'h3};
            xfer(m, 8'($urandom), 8'($urandom), 1'b1, 1'b1);
        end
        sa = 8'($urandom);
        xfer(8'hB2, 8'hFF, sa, 1'b1, 1'b1);
        rd(16'hFF60, 8'hF2);
        xfer(8'hB2, 8'h00, ~sa, 1'b1, 1'b1);
        rd(16'hFF60, 8'hB2);
        xfer(8'hBA, 8'h5A, sa, 1'b1, 1'b1);
        rd(16'hFF60, 8'hBA);
        repeat (2)
            xfer(8'h83, 8'($urandom), 8'($urandom), 1'b1, 1'b0);
        xfer(8'h87, 8'($urandom), 8'($urandom), 1'b0, 1'b0);
        `CHK(busy, 1'b1)
        repeat (3) pop();
        close_out();
    end
endmodule // tb_serial_channel_mode_control
